// ===== logic/ppe_regs.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
module ppe_regs #(
    parameter int PAT_BYTES = 64
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire logic [495:0] pattern_lo_i,
    input wire ppe_pkg::ppe_rx_byte_s rx_i,
    output logic match_o,
    output logic match_valid_o,
    input wire logic tx_er_i,
    input wire logic cap_strap_i,
    output logic lpi_req_o,
    output logic interrupt_powerdown_pin_o,
    output logic col_gpio_pin_o,
    input wire logic mmd3_cap_i,
    input wire logic mmd7_adv_i,
    input wire logic mmd7_lp_i,
    input wire logic np_rx_i,
    input wire logic lpi_quiet_i,
    output logic eee_adv_o,
    output logic eee_active_o,
    output logic np_accept_o,
    output logic rx_shutdown_o
);
    // ****************************************
    // State
    // ****************************************
    logic [15:0] pat_hi_q, pat_hi_d;
    logic [63:0] mask_q, mask_d;
    logic [5:0] start_q, start_d;
    logic txer_lpi_q, txer_lpi_d;
    logic [1:0] pin_sel_q, pin_sel_d;
    logic [11:0] b_rsvd_q, b_rsvd_d;
    logic bypass_q, bypass_d;
    logic np_dis_q, np_dis_d;
    logic rx_sd_q, rx_sd_d;
    logic cap_en_q, cap_en_d;
    logic [15:0] loop_bw_q, loop_bw_d;
    logic [15:0] rdata_d;
    logic strap_pend_q;
    logic [2:0] txer_s_q, strap_s_q;
    logic txer_q, txer_d;
    logic lpi_d, int_d, col_d, adv_d, act_d, npa_d, sd_d;
    logic lpi_q, int_q, col_q, adv_q, act_q, npa_q, sd_q;
    ppe_pkg::ppe_state_e st_q, st_d;
    logic [6:0] cnt_q, cnt_d;
    logic miss_q, miss_d;
    logic match_q, match_d, mvalid_q, mvalid_d;
    logic [511:0] pattern;
    logic [6:0] pos;
    logic [6:0] pos_end;
    logic [6:0] idx;
    logic in_win;
    logic byte_miss;

    function automatic logic unmasked_from(input logic [63:0] m, input logic [6:0] p);
        logic r;
        r = 1'b0;
        for (int i = 0; i < 64; i++) begin
            if (7'(i) >= p && !m[i]) begin
                r = 1'b1;
            end
        end
        return r;
    endfunction

    // ****************************************
    // Register file
    // ****************************************
    always_comb begin
        pat_hi_d = pat_hi_q;
        mask_d = mask_q;
        start_d = start_q;
        txer_lpi_d = txer_lpi_q;
        pin_sel_d = pin_sel_q;
        b_rsvd_d = b_rsvd_q;
        bypass_d = bypass_q;
        np_dis_d = np_dis_q;
        rx_sd_d = rx_sd_q;
        cap_en_d = cap_en_q;
        loop_bw_d = loop_bw_q;
        if (strap_pend_q && strap_s_q[1] == strap_s_q[2]) begin
            cap_en_d = strap_s_q[2];
        end
        if (wr_i) begin
            case (addr_i)
                ppe_pkg::ADDR_PAT_62_63: pat_hi_d = wdata_i;
                ppe_pkg::ADDR_MASK_0: mask_d[15:0] = wdata_i;
                ppe_pkg::ADDR_MASK_1: mask_d[31:16] = wdata_i;
                ppe_pkg::ADDR_MASK_2: mask_d[47:32] = wdata_i;
                ppe_pkg::ADDR_MASK_3: mask_d[63:48] = wdata_i;
                ppe_pkg::ADDR_CMP_CTRL: start_d = wdata_i[5:0];
                ppe_pkg::ADDR_LPI_A: begin
                    txer_lpi_d = wdata_i[ppe_pkg::LPI_A_TXER_LPI];
                    pin_sel_d = wdata_i[ppe_pkg::LPI_A_PIN_SEL +: 2];
                end
                ppe_pkg::ADDR_LPI_B: begin
                    b_rsvd_d = wdata_i[ppe_pkg::LPI_B_RSVD +: 12];
                    bypass_d = wdata_i[ppe_pkg::LPI_B_BYPASS];
                    np_dis_d = wdata_i[ppe_pkg::LPI_B_NP_DIS];
                    rx_sd_d = wdata_i[ppe_pkg::LPI_B_RX_SD];
                    cap_en_d = wdata_i[ppe_pkg::LPI_B_CAP_EN];
                end
                ppe_pkg::ADDR_LOOP_BW: loop_bw_d = wdata_i;
                default: begin
                end
            endcase
        end
        rdata_d = 16'h0000;
        if (rd_i) begin
            case (addr_i)
                ppe_pkg::ADDR_PAT_62_63: rdata_d = pat_hi_q;
                ppe_pkg::ADDR_MASK_0: rdata_d = mask_q[15:0];
                ppe_pkg::ADDR_MASK_1: rdata_d = mask_q[31:16];
                ppe_pkg::ADDR_MASK_2: rdata_d = mask_q[47:32];
                ppe_pkg::ADDR_MASK_3: rdata_d = mask_q[63:48];
                ppe_pkg::ADDR_CMP_CTRL: rdata_d = {10'h000, start_q};
                ppe_pkg::ADDR_LPI_A: begin
                    rdata_d = ppe_pkg::LPI_A_FIXED;
                    rdata_d[ppe_pkg::LPI_A_TXER_LPI] = txer_lpi_q;
                    rdata_d[ppe_pkg::LPI_A_PIN_SEL +: 2] = pin_sel_q;
                end
                ppe_pkg::ADDR_LPI_B: rdata_d = {b_rsvd_q, bypass_q, np_dis_q, rx_sd_q, cap_en_q};
                ppe_pkg::ADDR_LOOP_BW: rdata_d = loop_bw_q;
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pat_hi_q <= ppe_pkg::RST_PAT;
            mask_q <= {4{ppe_pkg::RST_MASK}};
            start_q <= ppe_pkg::RST_START;
            txer_lpi_q <= 1'b0;
            pin_sel_q <= 2'h0;
            b_rsvd_q <= ppe_pkg::RST_LPI_B_RSVD;
            bypass_q <= ppe_pkg::RST_BYPASS;
            np_dis_q <= 1'b0;
            rx_sd_q <= ppe_pkg::RST_RX_SD;
            cap_en_q <= 1'b0;
            loop_bw_q <= ppe_pkg::RST_LOOP_BW;
            rdata_o <= 16'h0000;
            strap_pend_q <= 1'b1;
        end else begin
            pat_hi_q <= pat_hi_d;
            mask_q <= mask_d;
            start_q <= start_d;
            txer_lpi_q <= txer_lpi_d;
            pin_sel_q <= pin_sel_d;
            b_rsvd_q <= b_rsvd_d;
            bypass_q <= bypass_d;
            np_dis_q <= np_dis_d;
            rx_sd_q <= rx_sd_d;
            cap_en_q <= cap_en_d;
            loop_bw_q <= loop_bw_d;
            rdata_o <= rdata_d;
            strap_pend_q <= 1'b0;
        end
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    always_ff @(posedge clk_i) begin
        txer_s_q <= {txer_s_q[1:0], tx_er_i};
        strap_s_q <= {strap_s_q[1:0], cap_strap_i};
    end

    // ****************************************
    // Low-power idle and negotiation controls
    // ****************************************
    always_comb begin
        txer_d = (txer_s_q[1] == txer_s_q[2]) ? txer_s_q[2] : txer_q;
        lpi_d = txer_lpi_q && txer_q;
        int_d = (pin_sel_q == ppe_pkg::PIN_INTERRUPT_POWERDOWN_PIN) && txer_q;
        col_d = (pin_sel_q == ppe_pkg::PIN_COL_GPIO) && txer_q;
        // Bypass uses the enable bit alone
        adv_d = cap_en_q && (bypass_q || (mmd3_cap_i && mmd7_adv_i));
        act_d = adv_d && mmd7_lp_i;
        npa_d = np_rx_i && !np_dis_q && cap_en_q;
        sd_d = rx_sd_q && lpi_quiet_i && act_q;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            txer_q <= 1'b0;
            {lpi_q, int_q, col_q, adv_q, act_q, npa_q, sd_q} <= 7'h00;
        end else begin
            txer_q <= txer_d;
            {lpi_q, int_q, col_q, adv_q, act_q, npa_q, sd_q} <=
                {lpi_d, int_d, col_d, adv_d, act_d, npa_d, sd_d};
        end
    end

    assign lpi_req_o = lpi_q;
    assign interrupt_powerdown_pin_o = int_q;
    assign col_gpio_pin_o = col_q;
    assign eee_adv_o = adv_q;
    assign eee_active_o = act_q;
    assign np_accept_o = npa_q;
    assign rx_shutdown_o = sd_q;

    // ****************************************
    // Pattern compare
    // ****************************************
    assign pattern = {pat_hi_q, pattern_lo_i};
    // Byte index taken from the counter, not its next value, so no loop
    assign idx = rx_i.first ? 7'h00 : ((cnt_q != 7'h7f) ? (cnt_q + 7'h01) : cnt_q);
    assign pos = idx - {1'b0, start_q};
    assign in_win = (idx >= {1'b0, start_q}) && (pos < 7'(PAT_BYTES));
    assign byte_miss = in_win && !mask_q[pos[5:0]] &&
        (pattern[pos[5:0]*8 +: 8] != rx_i.data);
    assign pos_end = (idx >= {1'b0, start_q}) ? (pos + 7'h01) : 7'h00;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        miss_d = miss_q;
        match_d = 1'b0;
        mvalid_d = 1'b0;
        if (rx_i.valid) begin
            if (rx_i.first) begin
                cnt_d = 7'h00;
                miss_d = 1'b0;
                st_d = ppe_pkg::PPE_RUN;
            end else if (cnt_q != 7'h7f) begin
                cnt_d = cnt_q + 7'h01;
            end
            if (rx_i.first || st_q == ppe_pkg::PPE_RUN) begin
                miss_d = miss_d || byte_miss;
                if (rx_i.last) begin
                    // Bytes past the frame end count as mismatches when unmasked
                    match_d = !miss_d && !unmasked_from(mask_q, pos_end);
                    mvalid_d = 1'b1;
                    st_d = ppe_pkg::PPE_IDLE;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_q <= ppe_pkg::PPE_IDLE;
            cnt_q <= 7'h00;
            miss_q <= 1'b0;
            match_q <= 1'b0;
            mvalid_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            miss_q <= miss_d;
            match_q <= match_d;
            mvalid_q <= mvalid_d;
        end
    end

    assign match_o = match_q;
    assign match_valid_o = mvalid_q;

    // ****************************************
    // Checks
    // ****************************************
    property p_lpi_gate;
        @(posedge clk_i) disable iff (reset_i) lpi_req_o |-> $past(txer_lpi_q) && $past(txer_q);
    endproperty
    a_lpi_gate: assert property (p_lpi_gate) else $error("LPI request without enable");
    property p_pin_int;
        @(posedge clk_i) disable iff (reset_i)
            (pin_sel_q == 2'h1 && txer_q) |=> interrupt_powerdown_pin_o && !col_gpio_pin_o;
    endproperty
    a_pin_int: assert property (p_pin_int) else $error("TX_ER not on power-down pin");
    property p_pin_none;
        @(posedge clk_i) disable iff (reset_i)
            (pin_sel_q == 2'h0 || pin_sel_q == 2'h3) |=> !interrupt_powerdown_pin_o && !col_gpio_pin_o;
    endproperty
    a_pin_none: assert property (p_pin_none) else $error("TX_ER routed with no pin");
    property p_start_reset;
        @(posedge clk_i) $fell(reset_i) |-> start_q == 6'h0c;
    endproperty
    a_start_reset: assert property (p_start_reset) else $error("Start point not twelve");
    property p_no_eee;
        @(posedge clk_i) disable iff (reset_i) !cap_en_q ##1 !cap_en_q |-> !eee_adv_o && !eee_active_o;
    endproperty
    a_no_eee: assert property (p_no_eee) else $error("EEE while disabled");
    property p_bypass;
        @(posedge clk_i) disable iff (reset_i) (bypass_q && cap_en_q) |=> eee_adv_o;
    endproperty
    a_bypass: assert property (p_bypass) else $error("Bypass did not advertise");
    property p_np;
        @(posedge clk_i) disable iff (reset_i) np_dis_q |=> !np_accept_o;
    endproperty
    a_np: assert property (p_np) else $error("Next page accepted while disabled");
    property p_sd;
        @(posedge clk_i) disable iff (reset_i) rx_shutdown_o |-> $past(rx_sd_q) && $past(lpi_quiet_i);
    endproperty
    a_sd: assert property (p_sd) else $error("Shutdown outside quiet");
    property p_neg;
        @(posedge clk_i) disable iff (reset_i) eee_active_o |-> $past(mmd7_lp_i) && $past(cap_en_q);
    endproperty
    a_neg: assert property (p_neg) else $error("EEE active without partner");
    property p_match;
        @(posedge clk_i) disable iff (reset_i) match_o |-> match_valid_o && !$past(miss_d);
    endproperty
    a_match: assert property (p_match) else $error("Match despite mismatch");
    property p_read;
        @(posedge clk_i) disable iff (reset_i)
            (rd_i && addr_i == 16'h04cc) |=> rdata_o == {10'h000, $past(start_q)};
    endproperty
    a_read: assert property (p_read) else $error("Start point read wrong");
    c_match: cover property (@(posedge clk_i) disable iff (reset_i) match_o);
    c_miss: cover property (@(posedge clk_i) disable iff (reset_i) match_valid_o && !match_o);
    c_lpi: cover property (@(posedge clk_i) disable iff (reset_i) lpi_req_o && col_gpio_pin_o);
endmodule

// ===== logic/ppe_pkg.sv
//
// Function
// - Pattern word holds byte 63 high, byte 62 low.
// - Four mask words, one bit per pattern byte; one excludes that byte.
// - Start point N begins the compare on byte N+1 after the delimiter.
// - Start point resets to twelve, skipping both MAC addresses.
// - TX_ER requests low-power idle only while its enable bit is set.
// - TX_ER routed: 01 interrupt/power-down pin, 10 collision pin, else none.
// - Bypass set: enable bit alone sets advertised abilities; else MMD registers.
// - Next-page disable bit set refuses received EEE next pages.
// - Shutdown bit set powers down analog receive path during quiet while EEE is active.
// - Enable set: negotiate EEE from advertisement and partner ability.
// - Enable clear: MMD capability and negotiation registers ignored, no EEE.
package ppe_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [15:0] ADDR_PAT_62_63 = 16'h04c7;
    localparam logic [15:0] ADDR_MASK_0 = 16'h04c8;
    localparam logic [15:0] ADDR_MASK_1 = 16'h04c9;
    localparam logic [15:0] ADDR_MASK_2 = 16'h04ca;
    localparam logic [15:0] ADDR_MASK_3 = 16'h04cb;
    localparam logic [15:0] ADDR_CMP_CTRL = 16'h04cc;
    localparam logic [15:0] ADDR_LPI_A = 16'h04d0;
    localparam logic [15:0] ADDR_LPI_B = 16'h04d1;
    localparam logic [15:0] ADDR_LOOP_BW = 16'h04d4;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int LPI_A_TXER_LPI = 14;
    localparam int LPI_A_PIN_SEL = 5;
    localparam int LPI_B_RSVD = 4;
    localparam int LPI_B_BYPASS = 3;
    localparam int LPI_B_NP_DIS = 2;
    localparam int LPI_B_RX_SD = 1;
    localparam int LPI_B_CAP_EN = 0;
    localparam logic [1:0] PIN_INTERRUPT_POWERDOWN_PIN = 2'h1;
    localparam logic [1:0] PIN_COL_GPIO = 2'h2;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] RST_PAT = 16'h0000;
    localparam logic [15:0] RST_MASK = 16'h0000;
    localparam logic [5:0] RST_START = 6'h0c;
    localparam logic [15:0] LPI_A_FIXED = 16'h0302;
    localparam logic [11:0] RST_LPI_B_RSVD = 12'h018;
    localparam logic RST_BYPASS = 1'b1;
    localparam logic RST_RX_SD = 1'b1;
    localparam logic [15:0] RST_LOOP_BW = 16'h7220;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        PPE_IDLE = 2'b00,
        PPE_RUN = 2'b01
    } ppe_state_e;
    typedef struct packed {
        logic valid;
        logic first;
        logic last;
        logic [7:0] data;
    } ppe_rx_byte_s;
endpackage

// ===== dv/ppe_mac_model.sv
`timescale 1ns/10ps
// ****************************************
// Data-side partner: drives TX_ER and the receive byte stream
// ****************************************
module ppe_mac_model (
    input wire logic clk_i,
    output logic tx_er_o,
    output ppe_pkg::ppe_rx_byte_s rx_o
);
    initial begin
        tx_er_o = 1'b0;
        rx_o = '0;
    end

    // Level on TX_ER, read as an idle request only when enabled
    task automatic drive_tx_er(input logic v);
        tx_er_o <= v;
    endtask

    // Released data shows the inverse of the last byte
    task automatic send_frame(input logic [7:0] b [0:69], input int n);
        for (int k = 0; k < n; k++) begin
            rx_o <= {1'b1, k == 0, k == n - 1, b[k]};
            @(posedge clk_i);
        end
        rx_o <= {1'b0, 1'b0, 1'b0, ~b[n - 1]};
    endtask
endmodule

// ===== dv/ppe_regs_tb.sv
`timescale 1ns/10ps
module ppe_regs_tb;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [15:0] addr_i = 16'h0000;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic cap_strap_i = 1'b1;
    logic mmd3_cap_i = 1'b0, mmd7_adv_i = 1'b0, mmd7_lp_i = 1'b0;
    logic np_rx_i = 1'b0, lpi_quiet_i = 1'b0;
    logic [495:0] pattern_lo_i;
    logic [15:0] rdata_o;
    logic match_o, match_valid_o, lpi_req_o, interrupt_powerdown_pin_o, col_gpio_pin_o;
    logic eee_adv_o, eee_active_o, np_accept_o, rx_shutdown_o, tx_er_w;
    ppe_pkg::ppe_rx_byte_s rx_w;
    logic [7:0] frm [0:69];
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;

    always #5 clk_i = ~clk_i;

    ppe_mac_model ppe_mac_model_i (.clk_i(clk_i), .tx_er_o(tx_er_w), .rx_o(rx_w));

    ppe_regs ppe_regs_i (
        .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pattern_lo_i(pattern_lo_i),
        .rx_i(rx_w), .match_o(match_o), .match_valid_o(match_valid_o),
        .tx_er_i(tx_er_w), .cap_strap_i(cap_strap_i), .lpi_req_o(lpi_req_o),
        .interrupt_powerdown_pin_o(interrupt_powerdown_pin_o),
        .col_gpio_pin_o(col_gpio_pin_o), .mmd3_cap_i(mmd3_cap_i), .mmd7_adv_i(mmd7_adv_i),
        .mmd7_lp_i(mmd7_lp_i), .np_rx_i(np_rx_i), .lpi_quiet_i(lpi_quiet_i),
        .eee_adv_o(eee_adv_o), .eee_active_o(eee_active_o), .np_accept_o(np_accept_o),
        .rx_shutdown_o(rx_shutdown_o)
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic complete_run();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic reg_rd(input logic [15:0] a, input logic [15:0] exp, input string what);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(what, exp, rdata_o);
        @(posedge clk_i);
    endtask

    // Sends a frame, then waits a bounded time for the verdict pulse
    task automatic frame(input int n, input logic exp, input string what);
        int i;
        ppe_mac_model_i.send_frame(frm, n);
        i = 0;
        #1;
        while (match_valid_o !== 1'b1 && i < 4) begin
            @(posedge clk_i);
            #1;
            i++;
        end
        chk(what, {14'h0, 1'b1, exp}, {14'h0, match_valid_o, match_o});
        @(posedge clk_i);
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            complete_run();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [8:0] v;
        logic adv, act;
        logic [495:0] lo;
        for (int i = 0; i < 62; i++) lo[8*i +: 8] = 8'(i + 1);
        pattern_lo_i <= lo;
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        reg_rd(ppe_pkg::ADDR_PAT_62_63, 16'h0000, "pat_62_63");
        for (int k = 0; k < 4; k++) begin
            reg_rd(ppe_pkg::ADDR_MASK_0 + 16'(k), 16'h0000, "mask");
        end
        reg_rd(ppe_pkg::ADDR_CMP_CTRL, 16'h000c, "cmp_ctrl");
        reg_rd(ppe_pkg::ADDR_LPI_A, 16'h0302, "lpi_a");
        reg_rd(ppe_pkg::ADDR_LPI_B, 16'h018b, "lpi_b");
        reg_rd(ppe_pkg::ADDR_LOOP_BW, 16'h7220, "loop_bw");
        reg_wr(ppe_pkg::ADDR_PAT_62_63, 16'ha55a);
        reg_rd(ppe_pkg::ADDR_PAT_62_63, 16'ha55a, "pat_62_63");
        reg_wr(ppe_pkg::ADDR_CMP_CTRL, 16'hffff);
        reg_rd(ppe_pkg::ADDR_CMP_CTRL, 16'h003f, "cmp_ctrl");
        reg_wr(ppe_pkg::ADDR_LPI_A, 16'hffff);
        reg_rd(ppe_pkg::ADDR_LPI_A, 16'h4362, "lpi_a");
        reg_wr(16'h04cd, 16'hffff);
        reg_rd(16'h04cd, 16'h0000, "unmapped");
        reg_wr(ppe_pkg::ADDR_LOOP_BW, 16'h1234);
        reg_rd(ppe_pkg::ADDR_LOOP_BW, 16'h1234, "loop_bw");
        // ****************************************
        // TX_ER routing and idle request
        // ****************************************
        ppe_mac_model_i.drive_tx_er(1'b1);
        for (int s = 0; s < 4; s++) begin
            reg_wr(ppe_pkg::ADDR_LPI_A, 16'h4000 | 16'(s << 5));
            repeat (8) @(posedge clk_i);
            #1;
            chk("lpi_req", 16'h0001, {15'h0, lpi_req_o});
            chk("int_pin", {15'h0, s == 1}, {15'h0, interrupt_powerdown_pin_o});
            chk("col_pin", {15'h0, s == 2}, {15'h0, col_gpio_pin_o});
            @(posedge clk_i);
        end
        reg_wr(ppe_pkg::ADDR_LPI_A, 16'h0020);
        repeat (8) @(posedge clk_i);
        #1;
        chk("lpi_req", 16'h0000, {15'h0, lpi_req_o});
        @(posedge clk_i);
        ppe_mac_model_i.drive_tx_er(1'b0);
        repeat (8) @(posedge clk_i);
        #1;
        chk("int_pin", 16'h0000, {15'h0, interrupt_powerdown_pin_o});
        @(posedge clk_i);
        // ****************************************
        // EEE controls, every combination
        // ****************************************
        for (int e = 0; e < 512; e++) begin
            v = 9'(e);
            mmd3_cap_i <= v[4];
            mmd7_adv_i <= v[3];
            mmd7_lp_i <= v[2];
            np_rx_i <= v[1];
            lpi_quiet_i <= v[0];
            reg_wr(ppe_pkg::ADDR_LPI_B, {12'h018, v[8:5]});
            repeat (3) @(posedge clk_i);
            #1;
            adv = v[5] & (v[8] | (v[4] & v[3]));
            act = adv & v[2];
            chk("eee_out", {12'h0, adv, act, v[1] & ~v[7] & v[5], v[6] & v[0] & act},
                {12'h0, eee_adv_o, eee_active_o, np_accept_o, rx_shutdown_o});
            @(posedge clk_i);
        end
        reg_rd(ppe_pkg::ADDR_LPI_B, 16'h018f, "lpi_b");
        // ****************************************
        // Pattern compare
        // ****************************************
        reg_wr(ppe_pkg::ADDR_MASK_0, 16'hfffc);
        reg_wr(ppe_pkg::ADDR_MASK_1, 16'hfffd);
        reg_wr(ppe_pkg::ADDR_MASK_2, 16'hffff);
        reg_wr(ppe_pkg::ADDR_MASK_3, 16'h3fff);
        reg_rd(ppe_pkg::ADDR_MASK_1, 16'hfffd, "mask");
        reg_wr(ppe_pkg::ADDR_CMP_CTRL, 16'h0002);
        for (int k = 0; k < 70; k++) frm[k] = 8'hee;
        for (int k = 0; k < 62; k++) frm[k + 2] = 8'(k + 1);
        frm[64] = 8'h5a;
        frm[65] = 8'ha5;
        frame(66, 1'b1, "match_full");
        frm[64] = 8'ha5;
        frm[65] = 8'h5a;
        frame(66, 1'b0, "match_swap");
        frm[64] = 8'h5a;
        frm[65] = 8'ha5;
        frm[7] = 8'h00;
        frame(66, 1'b1, "match_masked");
        frm[19] = 8'h00;
        frame(66, 1'b0, "match_unmasked");
        frm[19] = 8'h12;
        frame(60, 1'b0, "match_short");
        reg_wr(ppe_pkg::ADDR_CMP_CTRL, 16'h0003);
        frame(66, 1'b0, "match_shift");
        // ****************************************
        // Second reset with no strap applied
        // ****************************************
        cap_strap_i <= 1'b0;
        reset_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        reg_rd(ppe_pkg::ADDR_LPI_B, 16'h018a, "lpi_b");
        reg_rd(ppe_pkg::ADDR_CMP_CTRL, 16'h000c, "cmp_ctrl");
        complete_run();
    end
endmodule
